// [src/phe_handler_entry.sv]
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module phe_handler_entry
  import phe_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o,
  // pipeline side
  input  wire phe_retire_type   retire_i,
  input  wire logic             pipe_empty_i,
  input  wire logic             mchk_req_i,
  input  wire logic             arith_req_i,
  input  wire logic             intr_req_i,
  input  wire logic             tb_miss_i,
  input  wire logic             mm_fault_i,
  // fetch side
  output phe_redirect_type      redirect_o,
  output logic                  drain_req_o,
  output logic                  privileged_handler_mode,
  output logic                  istream_map_en,
  output logic                  intr_en,
  output logic                  illegal_opcode_fault,
  output logic                  phys_access_en,
  output logic                  ipr_access_en
);

  phe_state_type    state_reg;
  phe_state_type    state_next;
  logic [31:0]      handler_base_register;
  logic [31:0]      exception_return_pc;
  logic             mode_reg;
  phe_cause_type    cause_reg;
  phe_cause_type    pend_reg;
  logic [31:0]      pend_pc_reg;
  logic [13:0]      pend_off_reg;
  phe_redirect_type redir_reg;
  logic             ack_reg;

  // instruction decode
  wire logic [5:0]  major_op  = retire_i.instr[31:26];
  wire logic [25:0] func_fld  = retire_i.instr[25:0];
  wire logic        is_call   = retire_i.valid && (major_op == PHE_OP_LIBCALL);
  wire logic [PHE_NUM_RSVD-1:0] rsvd_vec;
  // one comparator per reserved code keeps the set easy to change in the package
  generate
    for (genvar g = 0; g < PHE_NUM_RSVD; g++)
    begin : g_rsvd
      phe_opcode_match #(
        .OP_W (6),
        .CODE (PHE_OP_RSVD[g])
      ) match_u (
        .op  (major_op),
        .hit (rsvd_vec[g])
      );
    end
  endgenerate
  wire logic        is_rsvd   = |rsvd_vec;
  wire logic        rsvd_hit  = retire_i.valid && is_rsvd;
  wire logic        rsvd_bad  = rsvd_hit && !mode_reg;
  wire logic        do_return = rsvd_hit && mode_reg && (major_op == PHE_OP_RETURN);

  // call entry: bit 7 picks region, low six bits pick a 64-byte slot
  wire logic [13:0] call_region = func_fld[PHE_UNPRIV_BIT] ? PHE_OFF_UNPRIV : PHE_OFF_PRIV;
  wire logic [13:0] call_off    = call_region
                                | {2'b00, func_fld[5:0], 6'b00_0000};

  // priority select; interrupts masked while in handler mode
  wire logic        intr_ok = intr_req_i && !mode_reg;
  phe_cause_type    sel_cause;
  logic [13:0]      sel_off;
  always_comb
  begin
    sel_cause = PHE_C_NONE;
    sel_off   = PHE_OFF_RESET;
    if (mchk_req_i)
    begin
      sel_cause = PHE_C_MCHK;
      sel_off   = PHE_OFF_MCHK;
    end
    else if (arith_req_i)
    begin
      sel_cause = PHE_C_ARITH;
      sel_off   = PHE_OFF_ARITH;
    end
    else if (rsvd_bad)
    begin
      sel_cause = PHE_C_ILLOP;
      sel_off   = PHE_OFF_ILLOP;
    end
    else if (mm_fault_i)
    begin
      sel_cause = PHE_C_MMFAULT;
      sel_off   = PHE_OFF_MMFAULT;
    end
    else if (tb_miss_i)
    begin
      sel_cause = PHE_C_TBMISS;
      sel_off   = PHE_OFF_TBMISS;
    end
    else if (intr_ok)
    begin
      sel_cause = PHE_C_INTR;
      sel_off   = PHE_OFF_INTR;
    end
    else if (is_call)
    begin
      sel_cause = PHE_C_CALL;
      sel_off   = call_off;
    end
  end
  // handler-mode faults other than machine check are not re-entered here
  // a machine check beats a return, so a machine check inside the handler is never lost
  wire logic        ev_take = (state_reg == PHE_S_RUN) && (sel_cause != PHE_C_NONE)
                              && (!mode_reg || sel_cause == PHE_C_MCHK);
  wire logic        drained = (state_reg == PHE_S_DRAIN) && pipe_empty_i;
  wire logic        leave_ok = do_return && (state_reg == PHE_S_RUN) && !ev_take;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PHE_S_BOOT:
      begin
        state_next = PHE_S_DRAIN;
      end
      PHE_S_DRAIN:
      begin
        if (pipe_empty_i)
        begin
          state_next = PHE_S_RUN;
        end
      end
      PHE_S_RUN:
      begin
        if (ev_take)
        begin
          state_next = PHE_S_DRAIN;
        end
      end
      default:
      begin
        state_next = PHE_S_BOOT;
      end
    endcase
  end

  // wishbone decode
  wire logic        wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic        hit_base = wb_adr_i == PHE_ADR_BASE;
  wire logic        hit_ret  = wb_adr_i == PHE_ADR_RET_PC;
  wire logic        hit_stat = wb_adr_i == PHE_ADR_STATUS;
  wire logic        hit_caus = wb_adr_i == PHE_ADR_CAUSE;
  wire logic        mapped   = hit_base || hit_ret || hit_stat || hit_caus;
  wire logic        wr_base  = wb_req && wb_we_i && hit_base;
  wire logic [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] rd_mux   = hit_base ? handler_base_register :
                               hit_ret  ? exception_return_pc :
                               hit_stat ? {29'h0000_0000, intr_en, istream_map_en, mode_reg} :
                               hit_caus ? {28'h000_0000, cause_reg} : 32'h0000_0000;

  // registered answer: ack or err always one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg  <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= wb_req && mapped;
      wb_err_o <= wb_req && !mapped;
      if (wb_req && !wb_we_i)
      begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      handler_base_register <= PHE_BASE_RST;
    end
    else if (wr_base)
    begin
      handler_base_register <= (handler_base_register & ~wmask) | (wb_dat_i & wmask);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= PHE_S_BOOT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // cause and pc are latched at the take, committed only once the pipeline is empty
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      exception_return_pc <= 32'h0000_0000;
      mode_reg            <= 1'b1;
      cause_reg           <= PHE_C_RESET;
      pend_reg            <= PHE_C_RESET;
      pend_pc_reg         <= 32'h0000_0000;
      pend_off_reg        <= PHE_OFF_RESET;
    end
    else if (ev_take)
    begin
      pend_reg     <= sel_cause;
      pend_pc_reg  <= retire_i.pc;
      pend_off_reg <= sel_off;
      mode_reg     <= 1'b1;
    end
    else if (drained)
    begin
      exception_return_pc <= pend_pc_reg;
      cause_reg           <= pend_reg;
    end
    else if (leave_ok)
    begin
      mode_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      redir_reg <= '0;
    end
    else
    begin
      redir_reg.valid <= drained || leave_ok;
      if (drained)
      begin
        redir_reg.target <= handler_base_register + {18'h0_0000, pend_off_reg};
      end
      else if (leave_ok)
      begin
        redir_reg.target <= exception_return_pc;
      end
    end
  end

  assign wb_ack_o                = ack_reg;
  assign redirect_o              = redir_reg;
  assign drain_req_o             = state_reg == PHE_S_DRAIN;
  assign privileged_handler_mode = mode_reg;
  assign istream_map_en          = !mode_reg;
  assign intr_en                 = !mode_reg;
  assign illegal_opcode_fault    = rsvd_bad;
  assign phys_access_en          = rsvd_hit && mode_reg;
  assign ipr_access_en           = rsvd_hit && mode_reg;

endmodule : phe_handler_entry

module phe_opcode_match
#(
  parameter int                OP_W = 6,
  parameter logic [OP_W-1:0]   CODE = '0
)
(
  input  wire logic [OP_W-1:0] op,
  output logic                 hit
);

  assign hit = op == CODE;

endmodule : phe_opcode_match

`default_nettype wire

// [src/phe_pkg.sv]
package phe_pkg;

  // wishbone register map (word aligned byte addresses)
  localparam logic [7:0]  PHE_ADR_BASE    = 8'h00;
  localparam logic [7:0]  PHE_ADR_RET_PC  = 8'h04;
  localparam logic [7:0]  PHE_ADR_STATUS  = 8'h08;
  localparam logic [7:0]  PHE_ADR_CAUSE   = 8'h0c;

  localparam logic [31:0] PHE_BASE_RST    = 32'h0000_0000;

  // entry offsets from the handler base
  localparam logic [13:0] PHE_OFF_RESET   = 14'h0000;
  localparam logic [13:0] PHE_OFF_MCHK    = 14'h0100;
  localparam logic [13:0] PHE_OFF_ARITH   = 14'h0200;
  localparam logic [13:0] PHE_OFF_INTR    = 14'h0300;
  localparam logic [13:0] PHE_OFF_TBMISS  = 14'h0400;
  localparam logic [13:0] PHE_OFF_MMFAULT = 14'h0500;
  localparam logic [13:0] PHE_OFF_ILLOP   = 14'h0600;
  localparam logic [13:0] PHE_OFF_PRIV    = 14'h2000;
  localparam logic [13:0] PHE_OFF_UNPRIV  = 14'h3000;

  // instruction fields
  localparam logic [5:0]  PHE_OP_LIBCALL  = 6'h00;
  localparam int          PHE_UNPRIV_BIT  = 7;
  localparam int          PHE_REGION_SH   = 6;
  localparam int          PHE_NUM_RSVD    = 5;
  localparam logic [5:0]  PHE_OP_RSVD [PHE_NUM_RSVD] = '{6'h19, 6'h1b, 6'h1d, 6'h1e, 6'h1f};
  localparam logic [5:0]  PHE_OP_RETURN   = 6'h1e;

  // cause codes
  typedef enum logic [3:0] {
    PHE_C_NONE    = 4'h0,
    PHE_C_RESET   = 4'h1,
    PHE_C_MCHK    = 4'h2,
    PHE_C_ARITH   = 4'h3,
    PHE_C_ILLOP   = 4'h4,
    PHE_C_MMFAULT = 4'h5,
    PHE_C_TBMISS  = 4'h6,
    PHE_C_INTR    = 4'h7,
    PHE_C_CALL    = 4'h8
  } phe_cause_type;

  typedef enum logic [2:0] {
    PHE_S_BOOT  = 3'b001,
    PHE_S_DRAIN = 3'b010,
    PHE_S_RUN   = 3'b100
  } phe_state_type;

  // retiring instruction from the pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] instr;
  } phe_retire_type;

  // redirect to fetch
  typedef struct packed {
    logic        valid;
    logic [31:0] target;
  } phe_redirect_type;

endpackage : phe_pkg

// [verif/phe_handler_entry_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module phe_handler_entry_checker
  import phe_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             nrst,
  input wire phe_retire_type   retire_i,
  input wire logic             pipe_empty_i,
  input wire logic             mchk_req_i,
  input wire phe_redirect_type redirect_o,
  input wire logic             drain_req_o,
  input wire logic             privileged_handler_mode,
  input wire logic             istream_map_en,
  input wire logic             intr_en,
  input wire logic             illegal_opcode_fault,
  input wire logic             phys_access_en,
  input wire logic             ipr_access_en
);
  wire logic [5:0] op   = retire_i.instr[31:26];
  wire logic       rsvd = retire_i.valid && (op inside {PHE_OP_RSVD});
  wire logic       mode = privileged_handler_mode;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_drained;
    drain_req_o && pipe_empty_i;
  endsequence
  sequence s_entered;
    redirect_o.valid && mode && !drain_req_o;
  endsequence
  a_drain_then_go: assert property (s_drained |=> s_entered)
    else $error("no dispatch after drain");
  a_go_after_drain: assert property (
    redirect_o.valid && mode |-> $past(drain_req_o && pipe_empty_i))
    else $error("dispatch without drain");
  a_illop_fault: assert property (illegal_opcode_fault == (rsvd && !mode))
    else $error("illegal opcode fault wrong");
  a_rsvd_enable: assert property (
    phys_access_en == (rsvd && mode) && ipr_access_en == (rsvd && mode))
    else $error("reserved access enable wrong");
  a_map_off: assert property (istream_map_en != mode)
    else $error("mapping on in handler mode");
  a_intr_off: assert property (intr_en != mode)
    else $error("interrupts on in handler mode");
  a_return_exit: assert property (
    rsvd && op == PHE_OP_RETURN && mode && !drain_req_o && !mchk_req_i
    |=> !mode && redirect_o.valid ##1 !redirect_o.valid)
    else $error("return did not leave handler mode");
  a_mchk_enter: assert property (mchk_req_i && !drain_req_o |=> mode && drain_req_o)
    else $error("machine check not taken");
endmodule : phe_handler_entry_checker

bind phe_handler_entry phe_handler_entry_checker chk_u (.clk_sys, .nrst, .retire_i, .pipe_empty_i,
  .mchk_req_i, .redirect_o, .drain_req_o, .privileged_handler_mode, .istream_map_en, .intr_en,
  .illegal_opcode_fault, .phys_access_en, .ipr_access_en);
`default_nettype wire

// [verif/phe_pipe_model.sv]
`timescale 1ns/10ps
`default_nettype none
module phe_pipe_model
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       drain_req_o,
  input  wire logic [3:0] lat,
  output logic            pipe_empty_i
);
  logic [3:0] cnt_reg;
  // lat sets how slowly the pipe empties; 0 answers in the first drain cycle
  wire logic [3:0] cnt_next = !drain_req_o ? 4'h0 : (cnt_reg == lat ? cnt_reg : cnt_reg + 4'h1);
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  assign pipe_empty_i = drain_req_o && cnt_reg == lat;
endmodule : phe_pipe_model
`default_nettype wire

// [verif/tb_privileged_handler_entry.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_privileged_handler_entry
  import phe_pkg::*;
;
  typedef struct packed {
    logic [4:0]  req;
    logic [31:0] instr;
    logic [13:0] off;
    logic [3:0]  cause;
  } phe_row_type;
  localparam logic [31:0] hbase = 32'h0001_0000;
  localparam logic [31:0] nop   = 32'h4000_0000;
  // req order: mchk, arith, mm fault, tb miss, intr
  phe_row_type rows [12] = '{
    '{5'h10, nop, PHE_OFF_MCHK, 4'h2}, '{5'h08, nop, PHE_OFF_ARITH, 4'h3},
    '{5'h04, nop, PHE_OFF_MMFAULT, 4'h5}, '{5'h02, nop, PHE_OFF_TBMISS, 4'h6},
    '{5'h01, nop, PHE_OFF_INTR, 4'h7}, '{5'h11, nop, PHE_OFF_MCHK, 4'h2},
    '{5'h0a, nop, PHE_OFF_ARITH, 4'h3}, '{5'h06, nop, PHE_OFF_MMFAULT, 4'h5},
    '{5'h03, 32'h83, PHE_OFF_TBMISS, 4'h6}, '{5'h00, 32'h83, 14'h30c0, 4'h8},
    '{5'h00, 32'h3f, 14'h2fc0, 4'h8}, '{5'h00, 32'hbf, 14'h3fc0, 4'h8}};
  logic        clk_sys, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
  logic        mchk_req_i, arith_req_i, intr_req_i, tb_miss_i, mm_fault_i, pipe_empty_i;
  logic        drain_req_o, privileged_handler_mode, istream_map_en, intr_en;
  logic        illegal_opcode_fault, phys_access_en, ipr_access_en;
  logic [3:0]  wb_sel_i, lat;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  phe_retire_type   retire_i;
  phe_redirect_type redirect_o;
  int          miscompares, check_count;
  phe_handler_entry dut_u (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .retire_i, .pipe_empty_i,
    .mchk_req_i, .arith_req_i, .intr_req_i, .tb_miss_i, .mm_fault_i, .redirect_o, .drain_req_o,
    .privileged_handler_mode, .istream_map_en, .intr_en, .illegal_opcode_fault,
    .phys_access_en, .ipr_access_en);
  phe_pipe_model pipe_u (.clk_sys, .nrst, .drain_req_o, .lat, .pipe_empty_i);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // values are read at the edge, so they are the ones the edge sampled
  task automatic wait_for(input bit rd);
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk_sys);
      if ((rd ? redirect_o.valid : wb_ack_o | wb_err_o) === 1'b1)
        return;
    end
    miscompares++;
    report_and_stop();
  endtask : wait_for
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wait_for(0);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic leave(input logic [31:0] pc);
    retire_i <= '{1'b1, 32'h0, {PHE_OP_RETURN, 26'h0}};
    @(posedge clk_sys);
    retire_i.valid <= 1'b0;
    wait_for(1);
    chk("return target", pc, redirect_o.target);
    chk("mode after return", 32'h0, 32'(privileged_handler_mode));
    chk("map after return", 32'h1, 32'(istream_map_en));
    chk("intr after return", 32'h1, 32'(intr_en));
  endtask : leave
  task automatic entry_checks(input logic [31:0] tgt, input logic [3:0] c, input logic [31:0] pc);
    wait_for(1);
    chk("entry target", tgt, redirect_o.target);
    intr_req_i <= 1'b1;
    wb(1'b0, PHE_ADR_CAUSE, 32'h0);
    chk("cause", 32'(c), q);
    wb(1'b0, PHE_ADR_RET_PC, 32'h0);
    chk("saved pc", pc, q);
    wb(1'b0, PHE_ADR_STATUS, 32'h0);
    chk("status in handler", 32'h1, q);
    chk("no entry while masked", 32'h0, 32'(drain_req_o));
    intr_req_i <= 1'b0;
    leave(pc);
  endtask : entry_checks
  task automatic do_reset(input logic [31:0] pc);
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    entry_checks(PHE_BASE_RST + 32'(PHE_OFF_RESET), 4'h1, pc);
    wb(1'b0, PHE_ADR_BASE, 32'h0);
    chk("base reset", PHE_BASE_RST, q);
  endtask : do_reset
  task automatic run_row(input phe_row_type r, input logic [31:0] pc);
    {mchk_req_i, arith_req_i, mm_fault_i, tb_miss_i, intr_req_i} <= r.req;
    retire_i <= '{1'b1, pc, r.instr};
    @(posedge clk_sys);
    // requests drop once taken, before the core is back in run state
    {mchk_req_i, arith_req_i, mm_fault_i, tb_miss_i, intr_req_i} <= 5'h0;
    retire_i.valid <= 1'b0;
    entry_checks(hbase + 32'(r.off), r.cause, pc);
  endtask : run_row
  initial
  begin
    nrst = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, mchk_req_i, arith_req_i, intr_req_i} = 6'h0;
    {tb_miss_i, mm_fault_i, wb_adr_i, wb_dat_i, lat} = '0;
    wb_sel_i = 4'hf;
    retire_i = '0;
    miscompares = 0;
    check_count = 0;
    do_reset(32'h0);
    wb(1'b1, PHE_ADR_BASE, hbase);
    wb(1'b0, PHE_ADR_BASE, 32'h0);
    chk("base", hbase, q);
    for (int i = 0; i < 12; i++)
    begin
      lat <= 4'(i % 4);
      run_row(rows[i], 32'h4000 + 32'(i) * 4);
    end
    for (int k = 0; k < PHE_NUM_RSVD; k++)
      run_row('{5'h0, {PHE_OP_RSVD[k], 26'h0}, PHE_OFF_ILLOP, 4'h4}, 32'h5000 + 32'(k));
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    do_reset(32'h0);
    report_and_stop();
  end
endmodule : tb_privileged_handler_entry
`default_nettype wire
